/* File: pkg/fec_pkg.sv */
// Constants and types shared by the flash erase command controller
package fec_pkg;
  // Register map of the software port
  localparam int REG_AW = 8;
  localparam logic [REG_AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [REG_AW-1:0] OFS_ADDR = 8'h04;
  localparam logic [REG_AW-1:0] OFS_STATUS = 8'h08;
  localparam logic [REG_AW-1:0] OFS_RDATA = 8'h0c;
  // CTRL command field
  localparam int CMD_LSB = 0;
  localparam int CMD_W = 3;
  // STATUS field positions
  localparam int ST_ENGINE_BUSY = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_REISSUE = 2;
  localparam int ST_SUSP_TIMEOUT = 3;
  localparam int ST_READY = 4;
  localparam int ST_MODE_LSB = 5;
  localparam int ST_MODE_W = 3;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  // Flash pin widths
  localparam int FA_W = 22;
  localparam int FD_W = 16;
  localparam int SECT_W = 7;
  localparam int SECT_LSB = 15;
  // Command cycle addresses and data
  localparam logic [FA_W-1:0] UNLOCK_A1 = 22'h000555;
  localparam logic [FA_W-1:0] UNLOCK_A2 = 22'h0002aa;
  localparam logic [FA_W-1:0] ANY_ADDR = 22'h000000;
  localparam logic [FD_W-1:0] UNLOCK_D1 = 16'h00aa;
  localparam logic [FD_W-1:0] UNLOCK_D2 = 16'h0055;
  localparam logic [FD_W-1:0] ERASE_SETUP = 16'h0080;
  localparam logic [FD_W-1:0] CHIP_ERASE = 16'h0010;
  localparam logic [FD_W-1:0] SECTOR_ERASE = 16'h0030;
  localparam logic [FD_W-1:0] ERASE_SUSPEND = 16'h00b0;
  localparam logic [FD_W-1:0] ERASE_RESUME = 16'h0030;
  localparam logic [FD_W-1:0] SOFT_RESET = 16'h00f0;
  localparam logic [2:0] ERASE_SEQ_LEN = 3'h6;
  // Timing, in nanoseconds and in 40 ns cycles
  localparam int CLK_NS = 40;
  localparam int TIMER_W = 11;
  localparam int PH_W = 4;
  localparam int WINDOW_NS = 50000;
  localparam int SUSPEND_NS = 20000;
  localparam int SETTLE_NS = 1000;
  localparam int HWRST_NS = 500;
  localparam int WE_LOW_NS = 50;
  localparam int ACCESS_NS = 90;
  localparam int DQ_SYNC_STAGES = 2;
  // Longest times round down, least times round up
  localparam logic [TIMER_W-1:0] WINDOW_CYC = TIMER_W'(WINDOW_NS / CLK_NS);
  localparam logic [TIMER_W-1:0] SUSPEND_CYC = TIMER_W'(SUSPEND_NS / CLK_NS);
  localparam logic [TIMER_W-1:0] SETTLE_CYC = TIMER_W'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TIMER_W-1:0] HWRST_CYC = TIMER_W'((HWRST_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [PH_W-1:0] WE_LOW_CYC = PH_W'((WE_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [PH_W-1:0] READ_CYC =
    PH_W'((ACCESS_NS + CLK_NS - 1) / CLK_NS + DQ_SYNC_STAGES);
  // Margin so an added sector write ends well inside the window
  localparam logic [TIMER_W-1:0] ADD_MARGIN_CYC = TIMER_W'(16);

  typedef enum logic [2:0] {
    CMD_READ = 3'h0,
    CMD_CHIP = 3'h1,
    CMD_SECTOR = 3'h2,
    CMD_ADD = 3'h3,
    CMD_SUSPEND = 3'h4,
    CMD_RESUME = 3'h5,
    CMD_SWRESET = 3'h6,
    CMD_HWRESET = 3'h7
  } fec_cmd_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_CHIP_RUN = 3'h1,
    OP_WINDOW = 3'h2,
    OP_SECT_RUN = 3'h3,
    OP_SUSP_PEND = 3'h4,
    OP_SUSPENDED = 3'h5
  } fec_op_t;

  typedef enum logic [2:0] {
    EN_IDLE = 3'h0,
    EN_STEP = 3'h1,
    EN_WAIT = 3'h2,
    EN_HWRST = 3'h3
  } fec_eng_t;

  typedef enum logic [2:0] {
    BC_IDLE = 3'h0,
    BC_SETUP = 3'h1,
    BC_WE = 3'h2,
    BC_HOLD = 3'h3,
    BC_READ = 3'h4
  } fec_bc_t;
endpackage : fec_pkg

/* File: verilog/fec_sync.sv */
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module fec_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Pins and synchronised levels
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;

  initial begin
    if (WIDTH < 1) begin
      $error("fec_sync: WIDTH must be at least 1");
    end
  end

  // The first stage feeds only the second stage
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        meta_q[i] <= 1'b1;
        syncOut[i] <= 1'b1;
      end else begin
        meta_q[i] <= pinIn[i];
        syncOut[i] <= meta_q[i];
      end
    end
  end
endmodule : fec_sync

/* File: verilog/fec_bus_cycle.sv */
// One asynchronous flash bus cycle: a command write or an array read
`timescale 1ns/1ps
module fec_bus_cycle
  import fec_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Cycle request
  input wire logic start,
  input wire logic isWrite,
  input wire logic [fec_pkg::FA_W-1:0] addrIn,
  input wire logic [fec_pkg::FD_W-1:0] dataIn,
  input wire logic [fec_pkg::FD_W-1:0] dqSync,
  output logic done,
  output logic [fec_pkg::FD_W-1:0] readData,
  // Flash pins
  output logic [fec_pkg::FA_W-1:0] flashAddr,
  output logic [fec_pkg::FD_W-1:0] flashDqOut,
  output logic flashDqOe,
  output logic flashCeN,
  output logic flashOeN,
  output logic flashWeN
);
  fec_bc_t state_q, state_d;
  logic [PH_W-1:0] ph_q, ph_d;
  logic [FA_W-1:0] addr_q, addr_d;
  logic [FD_W-1:0] dq_q, dq_d, rd_q, rd_d;
  logic dqOe_q, dqOe_d, ceN_q, ceN_d, oeN_q, oeN_d, weN_q, weN_d, done_q, done_d;

  always_comb begin
    state_d = state_q;
    ph_d = ph_q;
    addr_d = addr_q;
    dq_d = dq_q;
    rd_d = rd_q;
    dqOe_d = dqOe_q;
    ceN_d = ceN_q;
    oeN_d = oeN_q;
    weN_d = weN_q;
    done_d = 1'b0;
    case (state_q)
      BC_IDLE: begin
        if (start) begin
          addr_d = addrIn;
          dq_d = dataIn;
          ceN_d = 1'b0;
          ph_d = '0;
          if (isWrite) begin
            dqOe_d = 1'b1;
            state_d = BC_SETUP;
          end else begin
            oeN_d = 1'b0;
            state_d = BC_READ;
          end
        end
      end
      BC_SETUP: begin
        weN_d = 1'b0;
        state_d = BC_WE;
      end
      BC_WE: begin
        ph_d = ph_q + PH_W'(1);
        if (ph_q == WE_LOW_CYC - PH_W'(1)) begin
          // Data latches on this rising edge; hold a cycle before letting go
          weN_d = 1'b1;
          state_d = BC_HOLD;
        end
      end
      BC_HOLD: begin
        ceN_d = 1'b1;
        dqOe_d = 1'b0;
        done_d = 1'b1;
        state_d = BC_IDLE;
      end
      BC_READ: begin
        ph_d = ph_q + PH_W'(1);
        if (ph_q == READ_CYC - PH_W'(1)) begin
          // Access time plus synchroniser delay have passed
          rd_d = dqSync;
          ceN_d = 1'b1;
          oeN_d = 1'b1;
          done_d = 1'b1;
          state_d = BC_IDLE;
        end
      end
      default: state_d = BC_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= BC_IDLE;
      ph_q <= '0;
      addr_q <= '0;
      dq_q <= '0;
      rd_q <= '0;
      dqOe_q <= 1'b0;
      ceN_q <= 1'b1;
      oeN_q <= 1'b1;
      weN_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ph_q <= ph_d;
      addr_q <= addr_d;
      dq_q <= dq_d;
      rd_q <= rd_d;
      dqOe_q <= dqOe_d;
      ceN_q <= ceN_d;
      oeN_q <= oeN_d;
      weN_q <= weN_d;
      done_q <= done_d;
    end
  end

  assign done = done_q;
  assign readData = rd_q;
  assign flashAddr = addr_q;
  assign flashDqOut = dq_q;
  assign flashDqOe = dqOe_q;
  assign flashCeN = ceN_q;
  assign flashOeN = oeN_q;
  assign flashWeN = weN_q;
endmodule : fec_bus_cycle

/* File: verilog/fec_ctrl.sv */
// Host-side controller that drives erase sequences into a parallel NOR flash
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module fec_ctrl
  import fec_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Software register port
  input wire logic [fec_pkg::REG_AW-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Flash pins
  output logic [fec_pkg::FA_W-1:0] flashAddr,
  input wire logic [fec_pkg::FD_W-1:0] flashDqIn,
  output logic [fec_pkg::FD_W-1:0] flashDqOut,
  output logic flashDqOe,
  output logic flashCeN,
  output logic flashOeN,
  output logic flashWeN,
  output logic flashResetN,
  input wire logic flashReadyBusyN
);
  import fec_pkg::*;

  logic [FD_W-1:0] dqSync;
  logic readySync;
  logic bcStart, bcWrite, bcDone;
  logic [FA_W-1:0] bcAddr;
  logic [FD_W-1:0] bcData, bcReadData;

  fec_sync #(.WIDTH(FD_W + 1)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pinIn({flashReadyBusyN, flashDqIn}),
    .syncOut({readySync, dqSync})
  );

  fec_bus_cycle u_cycle (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(bcStart),
    .isWrite(bcWrite),
    .addrIn(bcAddr),
    .dataIn(bcData),
    .dqSync(dqSync),
    .done(bcDone),
    .readData(bcReadData),
    .flashAddr(flashAddr),
    .flashDqOut(flashDqOut),
    .flashDqOe(flashDqOe),
    .flashCeN(flashCeN),
    .flashOeN(flashOeN),
    .flashWeN(flashWeN)
  );

  // Address and data of one step of a command sequence
  function automatic logic [FA_W+FD_W-1:0] stepFor(
    input fec_cmd_t kind,
    input logic [2:0] idx,
    input logic [SECT_W-1:0] sect
  );
    logic [FA_W-1:0] sectAddr;
    sectAddr = {sect, {SECT_LSB{1'b0}}};
    case (kind)
      CMD_CHIP, CMD_SECTOR: begin
        case (idx)
          3'h0, 3'h3: stepFor = {UNLOCK_A1, UNLOCK_D1};
          3'h1, 3'h4: stepFor = {UNLOCK_A2, UNLOCK_D2};
          3'h2: stepFor = {UNLOCK_A1, ERASE_SETUP};
          default: begin
            if (kind == CMD_CHIP) begin
              stepFor = {UNLOCK_A1, CHIP_ERASE};
            end else begin
              stepFor = {sectAddr, SECTOR_ERASE};
            end
          end
        endcase
      end
      CMD_ADD: stepFor = {sectAddr, SECTOR_ERASE};
      CMD_SUSPEND: stepFor = {ANY_ADDR, ERASE_SUSPEND};
      CMD_RESUME: stepFor = {ANY_ADDR, ERASE_RESUME};
      CMD_SWRESET: stepFor = {ANY_ADDR, SOFT_RESET};
      default: stepFor = {ANY_ADDR, 16'h0000};
    endcase
  endfunction : stepFor

  // Engine, operation mode and registers
  fec_eng_t eng_q, eng_d;
  fec_op_t op_q, op_d;
  fec_cmd_t kind_q, kind_d;
  logic [2:0] idx_q, idx_d;
  logic [TIMER_W-1:0] tmr_q, tmr_d;
  logic [31:0] addrReg_q, addrReg_d;
  logic [FD_W-1:0] rdata_q, rdata_d;
  logic refused_q, refused_d, reissue_q, reissue_d, suspTo_q, suspTo_d;
  logic resetN_q, resetN_d, start_q, start_d;
  logic [31:0] regRdata_q, regRdata_d;
  logic [FA_W+FD_W-1:0] step;
  logic [31:0] status;

  fec_cmd_t newCmd;
  logic cmdWrite, legal, lastStep;

  assign newCmd = fec_cmd_t'(regWdata[CMD_LSB +: CMD_W]);
  assign cmdWrite = regWr && (regAddr == OFS_CTRL);
  assign step = stepFor(kind_q, idx_q, addrReg_q[SECT_LSB +: SECT_W]);
  assign lastStep = (kind_q == CMD_CHIP || kind_q == CMD_SECTOR) ?
    (idx_q == ERASE_SEQ_LEN - 3'h1) : 1'b1;

  // Which command the host may issue in each mode
  always_comb begin
    legal = 1'b0;
    if (newCmd == CMD_HWRESET || newCmd == CMD_READ) begin
      legal = 1'b1;
    end else begin
      case (op_q)
        OP_NONE: legal = (newCmd == CMD_CHIP || newCmd == CMD_SECTOR ||
                          newCmd == CMD_SWRESET);
        // Late adds are refused here rather than left to chance
        OP_WINDOW: legal = (newCmd == CMD_SUSPEND) || (newCmd == CMD_ADD &&
          tmr_q < WINDOW_CYC - ADD_MARGIN_CYC);
        OP_SECT_RUN: legal = (newCmd == CMD_SUSPEND);
        OP_SUSPENDED: legal = (newCmd == CMD_RESUME);
        default: legal = 1'b0;
      endcase
    end
  end

  always_comb begin
    eng_d = eng_q;
    op_d = op_q;
    kind_d = kind_q;
    idx_d = idx_q;
    tmr_d = tmr_q;
    addrReg_d = addrReg_q;
    rdata_d = rdata_q;
    refused_d = refused_q;
    reissue_d = reissue_q;
    suspTo_d = suspTo_q;
    resetN_d = resetN_q;
    start_d = 1'b0;
    if (tmr_q != {TIMER_W{1'b1}}) begin
      tmr_d = tmr_q + TIMER_W'(1);
    end
    // Software clears status flags by writing ones; hardware sets win below
    if (regWr && regAddr == OFS_STATUS) begin
      if (regWdata[ST_REFUSED]) refused_d = 1'b0;
      if (regWdata[ST_REISSUE]) reissue_d = 1'b0;
      if (regWdata[ST_SUSP_TIMEOUT]) suspTo_d = 1'b0;
    end
    if (regWr && regAddr == OFS_ADDR && eng_q == EN_IDLE) begin
      addrReg_d = regWdata;
    end
    // Device-side progress, watched only while no cycle is in flight
    if (eng_q == EN_IDLE) begin
      case (op_q)
        OP_WINDOW: begin
          if (tmr_q >= WINDOW_CYC) begin
            op_d = OP_SECT_RUN;
            tmr_d = '0;
          end
        end
        OP_CHIP_RUN, OP_SECT_RUN: begin
          // Ready high after settling means back in read mode
          if (tmr_q >= SETTLE_CYC && readySync) begin
            op_d = OP_NONE;
          end
        end
        OP_SUSP_PEND: begin
          if (tmr_q >= SETTLE_CYC && readySync) begin
            op_d = OP_SUSPENDED;
          end else if (tmr_q >= SUSPEND_CYC) begin
            op_d = OP_SUSPENDED;
            suspTo_d = 1'b1;
          end
        end
        default: op_d = op_q;
      endcase
    end
    case (eng_q)
      EN_IDLE: begin
        if (cmdWrite) begin
          if (!legal) begin
            refused_d = 1'b1;
          end else if (newCmd == CMD_HWRESET) begin
            resetN_d = 1'b0;
            tmr_d = '0;
            if (op_q != OP_NONE) reissue_d = 1'b1;
            op_d = OP_NONE;
            eng_d = EN_HWRST;
          end else begin
            kind_d = newCmd;
            idx_d = 3'h0;
            eng_d = EN_STEP;
          end
        end
      end
      EN_STEP: begin
        start_d = 1'b1;
        eng_d = EN_WAIT;
      end
      EN_WAIT: begin
        if (bcDone) begin
          if (kind_q == CMD_READ) begin
            rdata_d = bcReadData;
            eng_d = EN_IDLE;
          end else if (!lastStep) begin
            idx_d = idx_q + 3'h1;
            eng_d = EN_STEP;
          end else begin
            // Last write-enable has just risen
            eng_d = EN_IDLE;
            tmr_d = '0;
            case (kind_q)
              CMD_CHIP: begin
                op_d = OP_CHIP_RUN;
                reissue_d = 1'b0;
              end
              CMD_SECTOR: begin
                op_d = OP_WINDOW;
                reissue_d = 1'b0;
              end
              CMD_ADD: op_d = OP_WINDOW;
              CMD_SUSPEND: begin
                if (op_q == OP_WINDOW && tmr_q < WINDOW_CYC) begin
                  op_d = OP_SUSPENDED;
                end else begin
                  op_d = OP_SUSP_PEND;
                end
              end
              CMD_RESUME: op_d = OP_SECT_RUN;
              default: op_d = OP_NONE;
            endcase
          end
        end
      end
      EN_HWRST: begin
        if (tmr_q >= HWRST_CYC - TIMER_W'(1)) begin
          resetN_d = 1'b1;
          eng_d = EN_IDLE;
        end
      end
      default: eng_d = EN_IDLE;
    endcase
    if (refused_q && !(regWr && regAddr == OFS_STATUS && regWdata[ST_REFUSED])) begin
      refused_d = 1'b1;
    end
  end

  always_comb begin
    status = STATUS_RESET;
    status[ST_ENGINE_BUSY] = (eng_q != EN_IDLE);
    status[ST_REFUSED] = refused_q;
    status[ST_REISSUE] = reissue_q;
    status[ST_SUSP_TIMEOUT] = suspTo_q;
    status[ST_READY] = readySync;
    status[ST_MODE_LSB +: ST_MODE_W] = op_q;
    regRdata_d = 32'h0000_0000;
    if (regRd) begin
      case (regAddr)
        OFS_CTRL: regRdata_d = {29'h0, kind_q};
        OFS_ADDR: regRdata_d = addrReg_q;
        OFS_STATUS: regRdata_d = status;
        OFS_RDATA: regRdata_d = {16'h0000, rdata_q};
        default: regRdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      eng_q <= EN_IDLE;
      op_q <= OP_NONE;
      kind_q <= CMD_READ;
      idx_q <= 3'h0;
      tmr_q <= '0;
      addrReg_q <= ADDR_RESET;
      rdata_q <= '0;
      refused_q <= 1'b0;
      reissue_q <= 1'b0;
      suspTo_q <= 1'b0;
      resetN_q <= 1'b1;
      start_q <= 1'b0;
      regRdata_q <= 32'h0000_0000;
    end else begin
      eng_q <= eng_d;
      op_q <= op_d;
      kind_q <= kind_d;
      idx_q <= idx_d;
      tmr_q <= tmr_d;
      addrReg_q <= addrReg_d;
      rdata_q <= rdata_d;
      refused_q <= refused_d;
      reissue_q <= reissue_d;
      suspTo_q <= suspTo_d;
      resetN_q <= resetN_d;
      start_q <= start_d;
      regRdata_q <= regRdata_d;
    end
  end

  assign bcStart = start_q;
  assign bcWrite = (kind_q != CMD_READ);
  assign bcAddr = (kind_q == CMD_READ) ? addrReg_q[FA_W-1:0] : step[FA_W+FD_W-1:FD_W];
  assign bcData = step[FD_W-1:0];
  assign flashResetN = resetN_q;
  assign regRdata = regRdata_q;
endmodule : fec_ctrl

/* File: tb/fec_flash_model.sv */
// Behavioural parallel NOR flash that answers erase command sequences
`timescale 1ns/1ps
module fec_flash_model
  import fec_pkg::*;
#(
  parameter int ERASE_CYC = 200,
  parameter int WIN_CYC = 1250,
  parameter logic [15:0] SUSP_WORD = 16'h0088
) (
  // Bench clock and suspend speed
  input wire logic clk,
  input wire logic slow,
  // Flash pins
  input wire logic [fec_pkg::FA_W-1:0] flashAddr,
  input wire logic [fec_pkg::FD_W-1:0] dqWire,
  input wire logic flashCeN,
  input wire logic flashOeN,
  input wire logic flashWeN,
  input wire logic flashResetN,
  output logic [fec_pkg::FD_W-1:0] dqDrive,
  output logic flashReadyBusyN
);
  localparam logic [FA_W-1:0] SEQ_A [5] = '{UNLOCK_A1, UNLOCK_A2, UNLOCK_A1, UNLOCK_A1, UNLOCK_A2};
  localparam logic [FD_W-1:0] SEQ_D [5] = '{UNLOCK_D1, UNLOCK_D2, ERASE_SETUP, UNLOCK_D1, UNLOCK_D2};
  // Modes: 0 read, 1 chip erase, 2 window, 3 sector erase, 4 suspending, 5 suspended
  int st = 0;
  int step = 0;
  int tmr = 0;
  logic [127:0] listQ = '0;
  logic weQ = 1'b1;
  logic [15:0] cyc = 16'h0;
  wire logic weRise = flashWeN && !weQ && !flashCeN;
  wire logic [6:0] sect = flashAddr[21:15];

  always @(posedge clk) begin
    weQ <= flashWeN;
    cyc <= cyc + 16'h1;
    if (tmr > 0) tmr <= tmr - 1;
    if (!flashResetN) begin
      st <= 0;
      step <= 0;
      listQ <= '0;
    end else if (weRise) begin
      case (st)
        0: begin
          step <= 0;
          if (step == 5 && flashAddr == UNLOCK_A1 && dqWire == CHIP_ERASE) begin
            st <= 1;
            tmr <= ERASE_CYC;
          end else if (step == 5 && dqWire == SECTOR_ERASE) begin
            st <= 2;
            tmr <= WIN_CYC;
            listQ[sect] <= 1'b1;
          end else if (step < 5 && flashAddr == SEQ_A[step] && dqWire == SEQ_D[step]) begin
            step <= step + 1;
          end
        end
        2: if (dqWire == SECTOR_ERASE) begin
          listQ[sect] <= 1'b1;
          tmr <= WIN_CYC;
        end else if (dqWire == ERASE_SUSPEND) begin
          st <= 5;
        end else begin
          st <= 0;
          listQ <= '0;
        end
        3: if (dqWire == ERASE_SUSPEND) begin
          st <= 4;
          tmr <= slow ? 300 : 10;
        end
        5: if (dqWire == ERASE_RESUME) begin
          st <= 3;
          tmr <= ERASE_CYC;
        end
        default: ;
      endcase
    end else if (tmr == 1) begin
      if (st == 2 || st == 4) st <= st + 1;
      if (st == 2) tmr <= ERASE_CYC;
      if (st == 1 || st == 3) begin
        st <= 0;
        listQ <= '0;
      end
    end
  end

  assign flashReadyBusyN = !(st == 1 || st == 3 || st == 4);
  // Released bus shows a changing pattern so a late sample cannot pass by luck
  assign dqDrive = (!flashCeN && !flashOeN) ? ((st == 5 && listQ[sect]) ? SUSP_WORD
    : flashAddr[15:0] ^ 16'h5a5a) : cyc;
endmodule : fec_flash_model

/* File: tb/fec_ctrl_asserts.sv */
// Concurrent checks on the erase controller pins and register port
`timescale 1ns/1ps
module fec_ctrl_checker
  import fec_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [fec_pkg::REG_AW-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  // Flash pins
  input wire logic [fec_pkg::FA_W-1:0] flashAddr,
  input wire logic [fec_pkg::FD_W-1:0] flashDqIn,
  input wire logic [fec_pkg::FD_W-1:0] flashDqOut,
  input wire logic flashDqOe,
  input wire logic flashCeN,
  input wire logic flashOeN,
  input wire logic flashWeN,
  input wire logic flashResetN,
  input wire logic flashReadyBusyN
);
  logic [4:0] lowCnt_q;
  logic [4:0] lowCnt_d;
  // Reset pulse is too long for a repetition, so it is counted
  always_comb lowCnt_d = flashResetN ? 5'h0 : lowCnt_q + 5'h1;
  always_ff @(posedge clk) lowCnt_q <= sys_rst ? 5'h0 : lowCnt_d;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_RST_PINS: assert property (disable iff (1'b0) sys_rst |=>
    flashCeN && flashOeN && flashWeN && flashResetN && !flashDqOe) else $error("pins not idle");
  AST_RDATA_IDLE: assert property (!regRd |=> regRdata == 32'h0)
    else $error("read data outside answer cycle");
  AST_WE_LOW: assert property ($fell(flashWeN) |-> ##1 !flashWeN ##1 flashWeN)
    else $error("write pulse length");
  AST_WE_GAP: assert property ($rose(flashWeN) |-> flashWeN [*4])
    else $error("write pulses too close");
  AST_WE_FRAME: assert property (!flashWeN |-> !flashCeN && flashDqOe && flashOeN)
    else $error("write pulse outside cycle");
  AST_HOLD: assert property (!flashCeN && $past(!flashCeN) |->
    $stable(flashAddr) && $stable(flashDqOut) && $stable(flashDqOe)) else $error("cycle unstable");
  AST_WR_CE: assert property ($fell(flashCeN) && flashDqOe |-> !flashCeN [*4] ##1 flashCeN)
    else $error("write cycle length");
  AST_RD_CE: assert property ($fell(flashCeN) && !flashDqOe |->
    !flashOeN && !flashCeN [*5] ##1 (flashCeN && flashOeN)) else $error("read cycle length");
  AST_HWRST_LEN: assert property ($rose(flashResetN) && !$past(sys_rst) |-> lowCnt_q == 5'd13)
    else $error("reset pulse length");
  AST_DQ_DRIVE: assert property (flashDqOe |-> flashOeN)
    else $error("data bus contention");
endmodule : fec_ctrl_checker

bind fec_ctrl fec_ctrl_checker u_chk (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .flashAddr(flashAddr), .flashDqIn(flashDqIn), .flashDqOut(flashDqOut),
  .flashDqOe(flashDqOe), .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN),
  .flashResetN(flashResetN), .flashReadyBusyN(flashReadyBusyN));

/* File: tb/fec_tb.sv */
// Self-checking bench for the flash erase controller
`timescale 1ns/1ps
module testbench;
  import fec_pkg::*;
  localparam logic [15:0] SUSP_WORD = 16'h0088;
  logic clk, sys_rst, regWr, regRd, slow;
  logic rdPend = 1'b0;
  logic [REG_AW-1:0] regAddr;
  logic [31:0] regWdata, regRdata, e, m;
  logic [FA_W-1:0] flashAddr;
  logic [FD_W-1:0] flashDqIn, flashDqOut, modelDq;
  logic flashDqOe, flashCeN, flashOeN, flashWeN, flashResetN, flashReadyBusyN;
  logic [31:0] expQ[$], mskQ[$];
  logic [6:0] sec;
  int fails = 0;
  int n_tests = 0;

  fec_ctrl dut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .flashAddr(flashAddr),
    .flashDqIn(flashDqIn), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe),
    .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN),
    .flashResetN(flashResetN), .flashReadyBusyN(flashReadyBusyN));
  fec_flash_model #(.SUSP_WORD(SUSP_WORD)) u_flash (.clk(clk), .slow(slow),
    .flashAddr(flashAddr), .dqWire(flashDqIn), .flashCeN(flashCeN), .flashOeN(flashOeN),
    .flashWeN(flashWeN), .flashResetN(flashResetN), .dqDrive(modelDq),
    .flashReadyBusyN(flashReadyBusyN));
  assign flashDqIn = flashDqOe ? flashDqOut : modelDq;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic stop_test;
    if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  always @(posedge clk) rdPend <= regRd;
  // Read data stand only in the cycle after the strobe
  always @(negedge clk) begin
    if (rdPend && expQ.size() > 0) begin
      e = expQ.pop_front();
      m = mskQ.pop_front();
      if (m != 32'h0) begin
        n_tests++;
        if ((regRdata & m) !== e) begin
          fails++;
          $display("[ERR] %0t read %h expected %h mask %h", $time, regRdata, e, m);
        end
      end
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] k);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    expQ.push_back(x & k);
    mskQ.push_back(k);
    @(posedge clk);
    regRd <= 1'b0;
  endtask : rd

  task automatic waitSt(input logic [31:0] k, input logic [31:0] x);
    for (int i = 0; i < 3000; i++) begin
      rd(OFS_STATUS, 32'h0, 32'h0);
      @(negedge clk);
      if ((regRdata & k) === x) return;
    end
    fails++;
    $display("[ERR] %0t status wait timed out", $time);
    stop_test();
  endtask : waitSt

  task automatic flashRd(input logic [21:0] a, input logic [15:0] x);
    wr(OFS_ADDR, {10'h0, a});
    wr(OFS_CTRL, 32'h0);
    waitSt(32'h1, 32'h0);
    rd(OFS_RDATA, {16'h0, x}, 32'hffff);
  endtask : flashRd

  initial begin
    sys_rst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = '0;
    regWdata = '0;
    slow = 1'b0;
    void'($urandom(32'h9521));
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rd(OFS_STATUS, 32'h10, 32'hff);
    rd(OFS_ADDR, ADDR_RESET, '1);
    wr(8'h10, $urandom());
    rd(8'h10, 32'h0, '1);
    // Whole-array erase refuses suspend until done
    wr(OFS_CTRL, 32'h1);
    waitSt(32'he1, 32'h20);
    rd(OFS_STATUS, 32'h20, 32'hf3);
    wr(OFS_CTRL, 32'h4);
    rd(OFS_STATUS, 32'h22, 32'he3);
    waitSt(32'hf1, 32'h10);
    wr(OFS_STATUS, 32'he);
    rd(OFS_STATUS, 32'h10, 32'hff);
    // Sector erase with an added sector, suspended inside the window
    sec = 7'($urandom());
    wr(OFS_ADDR, {10'h0, sec, 15'h0});
    rd(OFS_ADDR, {10'h0, sec, 15'h0}, '1);
    wr(OFS_CTRL, 32'h2);
    waitSt(32'he1, 32'h40);
    wr(OFS_ADDR, {10'h0, sec ^ 7'h2, 15'h0});
    wr(OFS_CTRL, 32'h3);
    waitSt(32'he1, 32'h40);
    wr(OFS_CTRL, 32'h6);
    rd(OFS_STATUS, 32'h42, 32'he3);
    wr(OFS_STATUS, 32'h2);
    wr(OFS_CTRL, 32'h4);
    repeat (8) @(posedge clk);
    rd(OFS_STATUS, 32'hb0, 32'hf3);
    flashRd({sec ^ 7'h2, 15'h0123}, SUSP_WORD);
    flashRd({sec, 15'h0}, SUSP_WORD);
    flashRd({sec ^ 7'h4, 15'h0456}, {sec[0], 15'h0456} ^ 16'h5a5a);
    wr(OFS_CTRL, 32'h5);
    waitSt(32'he1, 32'h60);
    wr(OFS_CTRL, 32'h5);
    rd(OFS_STATUS, 32'h62, 32'he3);
    wr(OFS_STATUS, 32'h2);
    slow <= 1'b1;
    wr(OFS_CTRL, 32'h4);
    waitSt(32'he1, 32'ha0);
    rd(OFS_STATUS, 32'hb0, 32'hfb);
    slow <= 1'b0;
    wr(OFS_CTRL, 32'h5);
    waitSt(32'hf1, 32'h10);
    // Window runs out, then a hardware reset aborts the erase
    wr(OFS_ADDR, {10'h0, ~sec, 15'h0});
    wr(OFS_CTRL, 32'h2);
    waitSt(32'he1, 32'h60);
    wr(OFS_CTRL, 32'h6);
    rd(OFS_STATUS, 32'h62, 32'he3);
    wr(OFS_CTRL, 32'h7);
    waitSt(32'hf5, 32'h14);
    wr(OFS_STATUS, 32'he);
    wr(OFS_CTRL, 32'h6);
    waitSt(32'h1, 32'h0);
    rd(OFS_STATUS, 32'h10, 32'hff);
    rd(OFS_CTRL, 32'h6, 32'h7);
    // The last answer stands one cycle later and must reach the checker
    repeat (2) @(posedge clk);
    stop_test();
  end
endmodule : testbench
